// *** core/nvl_latch.sv ***
// Purpose: Octal latch or register with a background nonvolatile shadow and power-up restore
// Assumes: All inputs synchronous to i_clk_sys; i_power_good stands in for the supply monitor
// Notes:   i_rst_b models a cold start of the logic; the shadow keeps its value across power-good loss
//
// How it works
// RULE1 - Transparent variant: outputs follow data_in while strobe is high
// RULE2 - Transparent variant: strobe falling captures data_in and holds it
// RULE3 - Each latched bit is compared to its shadow copy separately
// RULE4 - Only differing bits are written into the shadow store
// RULE5 - Uncaptured transparent changes never cause shadow writes
// RULE6 - Shadow updates run only while supply-good is asserted
// RULE7 - Shadow writing never stalls or alters the user latch
// RULE8 - Shadow keeps the final latched state across power loss; a write in progress when supply-good falls is abandoned
// RULE9 - Power-up restore steers shadow content onto the internal data path
// RULE10 - Transparent restore holds internal strobe high the minimum time, then releases
// RULE11 - Edge restore makes one internal rising edge loading shadow content
// RULE12 - Restore completes within restore_time from supply-good rising
// RULE13 - Normal operation begins only after the restored value is loaded
// RULE14 - Host waits first_write_delay after supply-good before its first strobe
// RULE15 - Edge variant: outputs change only on a rising strobe edge
// RULE16 - State changes ignored below threshold; crossing above triggers restore
// RULE17 - Pending writes survive strobe bursts and complete afterwards
// RULE18 - Host avoids capturing during power-up so the restore survives
// RULE19 - Outputs driven while enable low, released while high
// RULE20 - Shadow write of a new state completes within 500 ns
// RULE21 - Build parameter picks variant; synchronous supply-good input
// RULE22 - Per-bit pending flag set on difference, cleared when write completes
module nvl_latch
#(
	parameter nvl_pkg::nvl_variant_t VARIANT = nvl_pkg::NVL_TRANSPARENT // RULE21
)
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_power_good,
	input  wire logic [nvl_pkg::WIDTH-1:0]  i_data_in,
	input  wire logic                       i_strobe,
	input  wire logic                       i_out_en_b,
	output logic      [nvl_pkg::WIDTH-1:0]  o_data_out,
	output logic      [nvl_pkg::WIDTH-1:0]  o_data_out_oe_b,
	output logic      [nvl_pkg::WIDTH-1:0]  o_pending,
	output logic                            o_restoring
);

	typedef enum logic [1:0] {NVL_OFF, NVL_RESTORE_HI, NVL_RESTORE_LO, NVL_RUN} nvl_state_t;

	localparam int unsigned SW = $clog2(nvl_pkg::STROBE_HIGH_CYC + 1);

	nvl_state_t                state;
	nvl_state_t                next_state;
	logic [SW-1:0]             hi_cnt;
	logic [SW-1:0]             next_hi_cnt;
	logic                      strobe_q;
	logic [nvl_pkg::WIDTH-1:0] held;
	logic [nvl_pkg::WIDTH-1:0] next_held;
	logic [nvl_pkg::WIDTH-1:0] data_out;
	logic [nvl_pkg::WIDTH-1:0] next_data_out;
	logic [nvl_pkg::WIDTH-1:0] oe_b;
	logic [nvl_pkg::WIDTH-1:0] next_oe_b;
	logic [nvl_pkg::WIDTH-1:0] pending;
	logic [nvl_pkg::WIDTH-1:0] next_pending;
	logic                      restoring;
	logic                      next_restoring;
	logic [nvl_pkg::WIDTH-1:0] shadow;
	logic [nvl_pkg::WIDTH-1:0] busy;
	nvl_pkg::nvl_feed_t        feed;
	nvl_pkg::nvl_wr_t          wr_req;

	// Internal data path: restore content replaces the pins until normal operation
	always_comb
	begin
		feed.data   = i_data_in;
		feed.strobe = i_strobe;
		case (state)
			NVL_OFF:
			begin
				feed.data   = held;
				feed.strobe = 1'b0; // RULE16
			end
			NVL_RESTORE_HI:
			begin
				feed.data   = shadow; // RULE9
				feed.strobe = 1'b1; // RULE10 RULE11
			end
			NVL_RESTORE_LO:
			begin
				feed.data   = shadow;
				feed.strobe = 1'b0;
			end
			default:
			begin
				feed.data   = i_data_in;
				feed.strobe = i_strobe;
			end
		endcase
	end

	// Power sequencer
	always_comb
	begin
		next_state     = state;
		next_hi_cnt    = hi_cnt;
		next_restoring = restoring;
		if (!i_power_good)
		begin
			next_state     = NVL_OFF; // RULE16
			next_restoring = 1'b0;
		end
		else
		begin
			case (state)
				NVL_OFF:
				begin
					next_state     = NVL_RESTORE_HI; // RULE16
					next_hi_cnt    = SW'(nvl_pkg::STROBE_HIGH_CYC);
					next_restoring = 1'b1;
				end
				NVL_RESTORE_HI:
				begin
					next_hi_cnt = hi_cnt - SW'(1);
					if (hi_cnt == SW'(1))
					begin
						next_state = NVL_RESTORE_LO; // RULE10
					end
				end
				NVL_RESTORE_LO:
				begin
					// Restore spans a handful of cycles, far inside restore_time
					next_state     = NVL_RUN; // RULE12 RULE13
					next_restoring = 1'b0;
				end
				default:
				begin
					next_state = NVL_RUN;
				end
			endcase
		end
	end

	// User latch; shadow activity has no path into this logic
	always_comb
	begin
		next_held     = held;
		next_data_out = data_out;
		if (!i_power_good)
		begin
			// Below threshold nothing is captured, not even a strobe that was high as supply fell
			next_held = held; // RULE16
		end
		else if (VARIANT == nvl_pkg::NVL_TRANSPARENT)
		begin
			if (feed.strobe)
			begin
				next_data_out = feed.data; // RULE1
			end
			else if (strobe_q)
			begin
				// Falling edge: the value seen in the last high cycle is kept
				next_held = data_out; // RULE2
			end
			else
			begin
				next_data_out = held; // RULE2
			end
		end
		else if (feed.strobe && !strobe_q)
		begin
			next_held     = feed.data; // RULE15
			next_data_out = feed.data; // RULE15
		end
		next_oe_b = {nvl_pkg::WIDTH{i_out_en_b}}; // RULE19
	end

	// Compare only the captured state, never the transparent outputs
	always_comb
	begin
		next_pending = (held ^ shadow) | busy; // RULE3 RULE5 RULE17 RULE22
		// No writes start before the restore has settled the latch, saving endurance
		wr_req.mask  = (state == NVL_RUN) ? (held ^ shadow) : '0; // RULE3
		wr_req.value = held;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state     <= NVL_OFF;
			hi_cnt    <= '0;
			restoring <= 1'b0;
			strobe_q  <= 1'b0;
			held      <= nvl_pkg::LATCH_RESET;
			data_out  <= nvl_pkg::LATCH_RESET;
			oe_b      <= '1;
			pending   <= '0;
		end
		else
		begin
			state     <= next_state;
			hi_cnt    <= next_hi_cnt;
			restoring <= next_restoring;
			strobe_q  <= feed.strobe;
			held      <= next_held;
			data_out  <= next_data_out;
			oe_b      <= next_oe_b;
			pending   <= next_pending;
		end
	end

	nvl_shadow u_shadow
	(
		.i_clk_sys    (i_clk_sys),
		.i_rst_b      (i_rst_b),
		.i_power_good (i_power_good), // RULE6
		.i_req        (wr_req), // RULE7
		.o_shadow     (shadow),
		.o_busy       (busy)
	);

	assign o_data_out      = data_out;
	assign o_data_out_oe_b = oe_b;
	assign o_pending       = pending;
	assign o_restoring     = restoring;

endmodule : nvl_latch

// *** core/nvl_shadow.sv ***
// Purpose: Per-bit shadow store with modelled write time
// Assumes: Request mask is held high while a bit is pending
// Notes:   Each bit runs its own write timer so bits never block each other
module nvl_shadow
(
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_power_good,
	input  wire nvl_pkg::nvl_wr_t        i_req,
	output logic [nvl_pkg::WIDTH-1:0]    o_shadow,
	output logic [nvl_pkg::WIDTH-1:0]    o_busy
);

	localparam int unsigned CW = $clog2(nvl_pkg::NV_BUSY_CYC + 1);

	logic [nvl_pkg::WIDTH-1:0] shadow;
	logic [nvl_pkg::WIDTH-1:0] next_shadow;
	logic [CW-1:0]             timer      [nvl_pkg::WIDTH];
	logic [CW-1:0]             next_timer [nvl_pkg::WIDTH];

	genvar g;
	generate
		for (g = 0; g < nvl_pkg::WIDTH; g++)
		begin : g_bit
			always_comb
			begin
				next_timer[g]  = timer[g];
				next_shadow[g] = shadow[g];
				if (!i_power_good)
				begin
					// Abandon a partial write; the bit stays pending until the restore reloads the old shadow value into the latch
					next_timer[g] = '0; // RULE6
				end
				else if (timer[g] != '0)
				begin
					next_timer[g] = timer[g] - CW'(1);
					if (timer[g] == CW'(1))
					begin
						next_shadow[g] = i_req.value[g]; // RULE4
					end
				end
				else if (i_req.mask[g])
				begin
					next_timer[g] = CW'(nvl_pkg::NV_BUSY_CYC); // RULE20
				end
			end

			always_ff @(posedge i_clk_sys or negedge i_rst_b)
			begin
				if (!i_rst_b)
				begin
					timer[g]  <= '0;
					shadow[g] <= nvl_pkg::SHADOW_RESET[g];
				end
				else
				begin
					timer[g]  <= next_timer[g];
					shadow[g] <= next_shadow[g];
				end
			end

			assign o_busy[g] = (timer[g] != '0);
		end
	endgenerate

	// Shadow survives loss of supply; only the async reset clears it
	assign o_shadow = shadow; // RULE8

endmodule : nvl_shadow

// *** dv/nvl_host.sv ***
// Purpose: Host logic driving data, strobe and output enable
// Assumes: Signals change only by non-blocking assignment at the rising edge
// Notes:   Holds off its first strobe after supply-good until the first-write delay
module nvl_host
(
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_power_good,
	output logic      [nvl_pkg::WIDTH-1:0] o_data_in,
	output logic                           o_strobe,
	output logic                           o_out_en_b
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned since_pg;

	initial
	begin
		o_data_in = 8'h00;
		o_strobe = 1'b0;
		o_out_en_b = 1'b1;
	end

	always @(posedge i_clk_sys)
		since_pg <= i_power_good ? since_pg + 1 : 0;

	task wait_ready();
		while (since_pg < nvl_pkg::FIRST_WRITE_DELAY_CYC)
			@(posedge i_clk_sys);
	endtask : wait_ready

	task drive(input logic [nvl_pkg::WIDTH-1:0] v, input logic s);
		@(posedge i_clk_sys);
		o_data_in <= v;
		o_strobe <= s;
	endtask : drive

	task enable(input logic b);
		@(posedge i_clk_sys);
		o_out_en_b <= b;
	endtask : enable
endmodule : nvl_host

// *** dv/nvl_latch_checker.sv ***
// Purpose: Port-level assertions for the nonvolatile octal latch
// Assumes: Variant handed in by the bind, all inputs synchronous to i_clk_sys
// Notes:   Shadow content is hidden, so pending and restore timing stand in for it
module nvl_latch_checker
#(
	parameter nvl_pkg::nvl_variant_t VARIANT = nvl_pkg::NVL_TRANSPARENT
)
(
	input wire logic                      i_clk_sys,
	input wire logic                      i_rst_b,
	input wire logic                      i_power_good,
	input wire logic [nvl_pkg::WIDTH-1:0] i_data_in,
	input wire logic                      i_strobe,
	input wire logic                      i_out_en_b,
	input wire logic [nvl_pkg::WIDTH-1:0] o_data_out,
	input wire logic [nvl_pkg::WIDTH-1:0] o_data_out_oe_b,
	input wire logic [nvl_pkg::WIDTH-1:0] o_pending,
	input wire logic                      o_restoring
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam bit TRANSP = (VARIANT == nvl_pkg::NVL_TRANSPARENT);
	// Allows a short strobe burst on top of one full write time
	localparam int unsigned PEND_MAX = nvl_pkg::NV_WRITE_CYC + 16;
	int unsigned pend_age;
	int unsigned next_pend_age;

	always_comb
	begin
		next_pend_age = (o_pending != 8'h00 && i_power_good) ? pend_age + 1 : 0;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pend_age <= 0;
		else
			pend_age <= next_pend_age;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	sequence s_run;
		(i_power_good && !o_restoring) [*4];
	endsequence
	sequence s_restore;
		##[1:2] o_restoring ##[1:122] !o_restoring;
	endsequence

	a_follow_high: assert property (s_run ##0 (TRANSP && i_strobe) |=> o_data_out == $past(i_data_in))
		else $error("output does not follow input");
	a_capture_fall: assert property (s_run ##0 (TRANSP && $fell(i_strobe)) |=> o_data_out == $past(i_data_in, 2))
		else $error("wrong value captured");
	a_hold_low: assert property (s_run ##0 (TRANSP && !i_strobe) [*2] |=> $stable(o_data_out))
		else $error("held value changed");
	a_no_spurious: assert property (TRANSP && $rose(o_pending != 8'h00) |-> $past(i_strobe, 3) && !$past(i_strobe, 2))
		else $error("pending without a capture");
	a_edge_hold: assert property (s_run ##0 (!TRANSP && !$rose(i_strobe)) |=> $stable(o_data_out))
		else $error("register changed without a rising strobe");
	a_write_time: assert property (pend_age <= PEND_MAX)
		else $error("shadow write too slow");
	a_restore_seq: assert property ($rose(i_power_good) |-> s_restore)
		else $error("restore late or missing");
	a_low_supply: assert property (!i_power_good [*2] |=> $stable(o_data_out) && $stable(o_pending))
		else $error("state changed below threshold");
	a_oe_track: assert property (1 |=> o_data_out_oe_b == {8{$past(i_out_en_b)}})
		else $error("output enable wrong");
endmodule : nvl_latch_checker

bind nvl_latch nvl_latch_checker #(.VARIANT(VARIANT)) u_chk (.i_clk_sys, .i_rst_b, .i_power_good, .i_data_in, .i_strobe,
	.i_out_en_b, .o_data_out, .o_data_out_oe_b, .o_pending, .o_restoring);

// *** dv/nvl_latch_test.sv ***
// Purpose: Self-checking bench for the transparent latch, with an edge register on the same stimulus
// Assumes: Shadow clears to 00 on cold reset
// Notes:   Power loss is modelled by dropping supply-good only
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR %0t got %h expected %h", $time, a, b); end end
module nvl_latch_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      i_clk_sys;
	logic                      i_rst_b;
	logic                      i_power_good;
	logic [nvl_pkg::WIDTH-1:0] i_data_in;
	logic                      i_strobe;
	logic                      i_out_en_b;
	logic [nvl_pkg::WIDTH-1:0] o_data_out;
	logic [nvl_pkg::WIDTH-1:0] o_data_out_oe_b;
	logic [nvl_pkg::WIDTH-1:0] o_pending;
	logic                      o_restoring;
	logic [nvl_pkg::WIDTH-1:0] o_edge_out;
	int                        bad_count = 0;
	int                        n_compared = 0;

	nvl_latch u_dut (.i_clk_sys, .i_rst_b, .i_power_good, .i_data_in, .i_strobe, .i_out_en_b,
		.o_data_out, .o_data_out_oe_b, .o_pending, .o_restoring);
	nvl_latch #(.VARIANT(nvl_pkg::NVL_EDGE)) u_dut_edge (.i_clk_sys, .i_rst_b, .i_power_good, .i_data_in, .i_strobe,
		.i_out_en_b, .o_data_out(o_edge_out), .o_data_out_oe_b(), .o_pending(), .o_restoring());
	nvl_host u_host (.i_clk_sys, .i_power_good, .o_data_in(i_data_in), .o_strobe(i_strobe),
		.o_out_en_b(i_out_en_b));

	initial
	begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	task close_out();
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : step

	task power(input logic up, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_power_good <= up;
		step(3);
		for (int i = 0; i < 125 && o_restoring !== 1'b0; i++)
			step(1);
		`CHK(o_restoring, 1'b0)
		`CHK(o_data_out, exp)
	endtask : power

	task wait_synced();
		for (int i = 0; i < 80 && o_pending !== 8'h00; i++)
			step(1);
		`CHK(o_pending, 8'h00)
	endtask : wait_synced

	task t_follow();
		u_host.wait_ready();
		u_host.drive(8'h3c, 1'b1);
		step(1);
		`CHK(o_data_out, 8'h3c)
		`CHK(o_edge_out, 8'h3c)
		u_host.drive(8'hc3, 1'b1);
		u_host.drive(8'h81, 1'b0);
		step(1);
		`CHK(o_data_out, 8'hc3)
		u_host.drive(8'h7e, 1'b0);
		step(2);
		`CHK(o_data_out, 8'hc3)
		`CHK(o_edge_out, 8'h3c)
		wait_synced();
	endtask : t_follow

	task t_low_supply();
		power(1'b0, 8'hc3);
		u_host.drive(8'h55, 1'b1);
		step(3);
		`CHK(o_data_out, 8'hc3)
		u_host.drive(8'h55, 1'b0);
		power(1'b1, 8'hc3);
		`CHK(o_edge_out, 8'h3c)
	endtask : t_low_supply

	task t_burst();
		u_host.wait_ready();
		u_host.drive(8'h11, 1'b1);
		u_host.drive(8'h22, 1'b1);
		u_host.drive(8'h44, 1'b1);
		u_host.drive(8'h88, 1'b1);
		u_host.drive(8'h88, 1'b0);
		step(2);
		`CHK(o_data_out, 8'h88)
		`CHK(o_edge_out, 8'h11)
		`CHK(o_pending != 8'h00, 1'b1)
		wait_synced();
		power(1'b0, 8'h88);
		power(1'b1, 8'h88);
	endtask : t_burst

	task t_abort();
		u_host.wait_ready();
		u_host.drive(8'h0f, 1'b1);
		u_host.drive(8'h0f, 1'b0);
		step(4);
		power(1'b0, 8'h0f);
		step(80);
		`CHK(o_pending, 8'h87)
		power(1'b1, 8'h88);
		`CHK(o_edge_out, 8'h11)
		step(1);
		`CHK(o_pending, 8'h00)
	endtask : t_abort

	task t_enable();
		u_host.enable(1'b0);
		step(2);
		`CHK(o_data_out_oe_b, 8'h00)
		u_host.enable(1'b1);
		step(2);
		`CHK(o_data_out_oe_b, 8'hff)
	endtask : t_enable

	initial
	begin
		i_rst_b = 1'b0;
		i_power_good = 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		power(1'b1, 8'h00);
		t_follow();
		t_low_supply();
		t_burst();
		t_abort();
		t_enable();
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		bad_count++;
		close_out();
	end
endmodule : nvl_latch_test

// *** include/nvl_pkg.sv ***
// Purpose: Shared constants and carrier types for the nonvolatile octal latch
// Assumes: 125 MHz system clock, synchronous host inputs
// Notes:   Times are kept in their own unit; cycle counts derive from them
package nvl_pkg;

	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned WIDTH         = 8;

	// Longest allowed shadow write, rounded down to whole cycles
	localparam int unsigned NV_WRITE_NS     = 500;
	localparam int unsigned NV_WRITE_CYC    = NV_WRITE_NS / CLK_PERIOD_NS;
	// Modelled write takes a fixed share of the allowed time
	localparam int unsigned NV_BUSY_CYC     = NV_WRITE_CYC / 2;

	// Restore must finish within this, rounded down
	localparam int unsigned RESTORE_TIME_NS  = 1000;
	localparam int unsigned RESTORE_TIME_CYC = RESTORE_TIME_NS / CLK_PERIOD_NS;
	// Host must wait at least this before its first strobe, rounded up
	localparam int unsigned FIRST_WRITE_DELAY_NS  = 1500;
	localparam int unsigned FIRST_WRITE_DELAY_CYC =
		(FIRST_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Least internal strobe high time, rounded up
	localparam int unsigned STROBE_HIGH_NS  = 8;
	localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [WIDTH-1:0] SHADOW_RESET  = 8'h00;
	localparam logic [WIDTH-1:0] LATCH_RESET   = 8'h00;

	typedef enum logic {NVL_TRANSPARENT, NVL_EDGE} nvl_variant_t;

	// Data path that feeds the user latch
	typedef struct packed
	{
		logic             strobe;
		logic [WIDTH-1:0] data;
	} nvl_feed_t;

	// Per-bit shadow write request
	typedef struct packed
	{
		logic [WIDTH-1:0] mask;
		logic [WIDTH-1:0] value;
	} nvl_wr_t;

endpackage : nvl_pkg
